/* File: shared/sfrpe_pkg.sv */
// Constants, types and lock decode for the serial flash command sequencer.
// Assumes a host in SPI mode 0 and a 25 MHz core clock.
// Behaviour
// - Fast read needs dummy byte; output off until then
// - Read address increments per byte, wraps to zero
// - Read data shifted out MSB first
// - Chip select high ends read, back to standby
// - 256-byte pages, 512 pages; program only clears bits
// - Program starts at chip select rise after LSB
// - Status bit 0 high during program cycle
// - Only status read accepted while program runs
// - Program 1-256 bytes, wrap within page, overwrite
// - Unaddressed bytes of the page stay unchanged
// - Program completion clears write-enable state
// - Write without enable ignored until new frame
// - 4K sectors, 32K blocks, four blocks
// - Sector erase sets unlocked 4K sector to ones
// - Block erase sets unlocked 32K block to ones
// - Chip erase skips locked sectors, eight seconds typical
// - Erase needs enable; busy bit high while erasing
// - Erase completion clears write-enable state
// - Block-protect sectors refuse program and erase
package sfrpe_pkg;
    localparam int ADDR_W     = 17;
    localparam int PAGE_BYTES = 256;
    localparam int PAGES      = 512;
    localparam int MEM_BYTES  = PAGE_BYTES * PAGES;
    localparam int TMR_W      = 28;

    localparam logic [16:0] SECT_MASK    = 17'h1F000;
    localparam logic [16:0] SECT_SPAN    = 17'h00FFF;
    localparam logic [16:0] BLOCK_MASK   = 17'h18000;
    localparam logic [16:0] BLOCK_SPAN   = 17'h07FFF;
    localparam logic [16:0] ARRAY_LAST   = 17'h1FFFF;
    localparam logic [16:0] LOCK_HALF    = 17'h10000;
    localparam logic [16:0] LOCK_QUARTER = 17'h18000;
    localparam logic [16:0] LOCK_EIGHTH  = 17'h1C000;
    localparam logic [16:0] LOCK_16TH    = 17'h1E000;
    localparam logic [16:0] LOCK_32ND    = 17'h1F000;

    // Block-protect port layout
    localparam int BP0_POS = 0;
    localparam int BP1_POS = 1;
    localparam int BP3_POS = 2;
    localparam int BP4_POS = 3;

    // Rising-edge counts within a frame
    localparam logic [5:0] OPC_LAST   = 6'h07;
    localparam logic [5:0] ADDR_HI    = 6'h0F;
    localparam logic [5:0] ADDR_MID   = 6'h17;
    localparam logic [5:0] ADDR_LAST  = 6'h1F;
    localparam logic [5:0] DATA_START = 6'h20;
    localparam logic [5:0] DATA_END   = 6'h27;
    localparam logic [5:0] RD_START   = 6'h28;
    localparam logic [5:0] RD_END     = 6'h2F;
    localparam logic [5:0] CNT_SAT    = 6'h3F;

    localparam int unsigned CORE_HZ        = 25_000_000;
    localparam int unsigned CHIP_ERASE_S   = 8;
    localparam int unsigned PROG_TIME_US   = 1000;
    localparam int unsigned SECT_ERASE_MS  = 100;
    localparam int unsigned BLOCK_ERASE_MS = 500;
    localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_S * CORE_HZ;
    localparam int unsigned PROG_CYC       =
        PROG_TIME_US * (CORE_HZ / 1_000_000);
    localparam int unsigned SECT_ERASE_CYC =
        SECT_ERASE_MS * (CORE_HZ / 1_000);
    localparam int unsigned BLOCK_ERASE_CYC =
        BLOCK_ERASE_MS * (CORE_HZ / 1_000);

    typedef enum logic [2:0] {
        K_NONE   = 3'h0,
        K_READ   = 3'h1,
        K_PROG   = 3'h2,
        K_SERASE = 3'h3,
        K_BERASE = 3'h4,
        K_CERASE = 3'h5
    } sfrpe_kind_e;

    typedef struct packed {
        sfrpe_kind_e       kind;
        logic [ADDR_W-1:0] addr;
    } sfrpe_cmd_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DONE  = 4'b1000
    } sfrpe_state_e;

    // Lock regions all reach the top of the array
    function automatic logic sfrpe_locked(input logic [16:0] a,
                                          input logic [3:0]  bp);
        logic hit;
        hit = 1'b0;
        if (bp[BP1_POS] && bp[BP0_POS])
            hit = 1'b1;
        else if (bp[BP1_POS])
            hit = (a >= LOCK_HALF);
        else if (bp[BP0_POS])
            hit = (a >= LOCK_QUARTER);
        else if (bp[BP4_POS] && bp[BP3_POS])
            hit = (a >= LOCK_EIGHTH);
        else if (bp[BP4_POS])
            hit = (a >= LOCK_16TH);
        else if (bp[BP3_POS])
            hit = (a >= LOCK_32ND);
        return hit;
    endfunction
endpackage

/* File: verilog/sfrpe_core.sv */
// Fast read, page program and erase sequencer of the serial flash.
// Assumes SPI mode 0 on SCK, write-enable and protect bits from
// neighbouring logic on CORE_CLK, and status read handled elsewhere.
`timescale 1ns/10ps
module sfrpe_core
    import sfrpe_pkg::*;
#(
    parameter logic [7:0]  OP_FAST_READ = 8'h0B,
    parameter logic [7:0]  OP_PROGRAM   = 8'h02,
    parameter logic [7:0]  OP_SECT_ERS  = 8'h20,
    parameter logic [7:0]  OP_BLOCK_ERS = 8'h52,
    parameter logic [7:0]  OP_CHIP_ERS  = 8'h60,
    parameter int unsigned PROG_CYCLES  = PROG_CYC,
    parameter int unsigned SECT_CYCLES  = SECT_ERASE_CYC,
    parameter int unsigned BLOCK_CYCLES = BLOCK_ERASE_CYC,
    parameter int unsigned CHIP_CYCLES  = CHIP_ERASE_CYC
)
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       SCK,
    input  wire logic       CS_N,
    input  wire logic       SI,
    output logic            SO,
    output logic            SO_OE,
    input  wire logic       WEL,
    input  wire logic [3:0] BP,
    output logic            BUSY,
    output logic            WEL_CLR
);

    logic [7:0]          mem_arr [0:MEM_BYTES-1];
    logic [7:0]          page_buf [0:PAGE_BYTES-1];

    // Link side, SCK domain
    logic [5:0]          cnt_reg;
    logic [5:0]          cnt_next;
    logic [7:0]          sh_reg;
    logic [7:0]          byte_in;
    logic                wel_m_reg;
    logic                wel_s_reg;
    logic                busy_m_reg;
    logic                busy_s_reg;
    sfrpe_cmd_s          cmd_reg;
    logic [7:0]          pg_idx_reg;
    logic [PAGE_BYTES-1:0] mask_reg;
    logic                prog_byte_done;
    logic                complete_reg;
    logic                rd_first_reg;
    logic [ADDR_W-1:0]   rd_ptr_reg;
    logic [ADDR_W-1:0]   rd_addr;
    logic [7:0]          out_sh_reg;
    logic                so_reg;
    logic                so_oe_reg;

    // Core side
    logic                cs_m_reg;
    logic                cs_s_reg;
    logic                cs_d_reg;
    logic                cs_rise;
    sfrpe_state_e        state_reg;
    sfrpe_state_e        state_next;
    logic                start;
    logic                refuse;
    logic                erase_reg;
    logic [ADDR_W-1:0]   ptr_reg;
    logic [ADDR_W-1:0]   end_reg;
    logic [ADDR_W-1:0]   base;
    logic [ADDR_W-1:0]   last;
    logic [TMR_W-1:0]    tmr_reg;
    logic [TMR_W-1:0]    tmr_load;
    logic                busy_reg;
    logic                wel_clr_reg;

    function automatic sfrpe_kind_e sfrpe_decode(input logic [7:0] op,
                                                 input logic busy,
                                                 input logic wen);
        sfrpe_kind_e k;
        k = K_NONE;
        if (op == OP_FAST_READ)
            k = K_READ;
        else if (op == OP_PROGRAM)
            k = K_PROG;
        else if (op == OP_SECT_ERS)
            k = K_SERASE;
        else if (op == OP_BLOCK_ERS)
            k = K_BERASE;
        else if (op == OP_CHIP_ERS)
            k = K_CERASE;
        // Ignored kinds fall through to standby at chip select rise
        if (busy)
            k = K_NONE;
        else if (k != K_READ && !wen)
            k = K_NONE;
        return k;
    endfunction

    // ---------------- SCK domain, rising edge ----------------

    assign byte_in = {sh_reg[6:0], SI};

    always_comb
    begin
        cnt_next = cnt_reg + 6'h01;
        if (cmd_reg.kind == K_READ && cnt_reg == RD_END)
            cnt_next = RD_START;
        else if (cmd_reg.kind == K_PROG && cnt_reg == DATA_END)
            cnt_next = DATA_START;
        else if (cnt_reg == CNT_SAT)
            cnt_next = CNT_SAT;
    end

    // Frame counter is cleared whenever chip select is high
    always_ff @(posedge SCK or posedge CS_N or posedge RST)
    begin
        if (RST || CS_N)
            cnt_reg <= 6'h00;
        else
            cnt_reg <= cnt_next;
    end

    always_ff @(posedge SCK)
    begin
        sh_reg <= byte_in;
    end

    // Core levels caught on SCK; frames give enough edges to settle
    always_ff @(posedge SCK or posedge RST)
    begin
        if (RST)
        begin
            wel_m_reg  <= 1'b0;
            wel_s_reg  <= 1'b0;
            busy_m_reg <= 1'b0;
            busy_s_reg <= 1'b0;
        end
        else
        begin
            wel_m_reg  <= WEL;
            wel_s_reg  <= wel_m_reg;
            busy_m_reg <= busy_reg;
            busy_s_reg <= busy_m_reg;
        end
    end

    always_ff @(posedge SCK or posedge RST)
    begin
        if (RST)
            cmd_reg <= '{kind: K_NONE, addr: '0};
        else if (cnt_reg == OPC_LAST)
            cmd_reg.kind <= sfrpe_decode(byte_in, busy_s_reg, wel_s_reg);
        else if (cnt_reg == ADDR_HI || cnt_reg == ADDR_MID ||
                 cnt_reg == ADDR_LAST)
            cmd_reg.addr <= {cmd_reg.addr[8:0], byte_in};
    end

    assign prog_byte_done = (cmd_reg.kind == K_PROG) &&
                            (cnt_reg >= DATA_START) &&
                            (cnt_reg[2:0] == 3'h7);

    always_ff @(posedge SCK or posedge RST)
    begin
        if (RST)
            pg_idx_reg <= 8'h00;
        else if (cnt_reg == ADDR_LAST)
            pg_idx_reg <= byte_in;
        else if (prog_byte_done)
            pg_idx_reg <= pg_idx_reg + 8'h01;
    end

    always_ff @(posedge SCK)
    begin
        if (prog_byte_done)
            page_buf[pg_idx_reg] <= byte_in;
    end

    always_ff @(posedge SCK or posedge RST)
    begin
        if (RST)
            mask_reg <= '0;
        else if (cnt_reg == OPC_LAST && !busy_s_reg)
            mask_reg <= '0;
        else if (prog_byte_done)
            mask_reg[pg_idx_reg] <= 1'b1;
    end

    // True only if the last edge closed a byte; any later bit voids it
    always_ff @(posedge SCK or posedge RST)
    begin
        if (RST)
            complete_reg <= 1'b0;
        else
            complete_reg <= prog_byte_done ||
                            ((cmd_reg.kind == K_SERASE ||
                              cmd_reg.kind == K_BERASE) &&
                             cnt_reg == ADDR_LAST) ||
                            (cnt_reg == OPC_LAST && sfrpe_decode(byte_in,
                             busy_s_reg, wel_s_reg) == K_CERASE);
    end

    // ---------------- SCK domain, falling edge ----------------

    assign rd_addr = rd_first_reg ? cmd_reg.addr : rd_ptr_reg;

    always_ff @(negedge SCK or posedge CS_N or posedge RST)
    begin
        if (RST || CS_N)
        begin
            so_reg       <= 1'b0;
            so_oe_reg    <= 1'b0;
            rd_first_reg <= 1'b1;
            rd_ptr_reg   <= '0;
            out_sh_reg   <= 8'h00;
        end
        else if (cmd_reg.kind == K_READ && cnt_reg >= RD_START &&
                 cnt_reg[2:0] == 3'h0)
        begin
            // Output stays off until the dummy byte is in
            out_sh_reg   <= mem_arr[rd_addr];
            so_reg       <= mem_arr[rd_addr][7];
            so_oe_reg    <= 1'b1;
            rd_first_reg <= 1'b0;
            rd_ptr_reg   <= rd_addr + 17'h00001;
        end
        else if (so_oe_reg)
        begin
            so_reg     <= out_sh_reg[6];
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
    end

    assign SO    = so_reg;
    assign SO_OE = so_oe_reg;

    // ---------------- Core domain ----------------

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            cs_d_reg <= 1'b1;
        end
        else
        begin
            cs_m_reg <= CS_N;
            cs_s_reg <= cs_m_reg;
            cs_d_reg <= cs_s_reg;
        end
    end

    // Frame data is static once chip select is high and SCK idles
    assign cs_rise = cs_s_reg && !cs_d_reg;

    always_comb
    begin
        base     = '0;
        last     = ARRAY_LAST;
        tmr_load = TMR_W'(CHIP_CYCLES);
        case (cmd_reg.kind)
            K_PROG:
            begin
                base     = {cmd_reg.addr[16:8], 8'h00};
                last     = {cmd_reg.addr[16:8], 8'hFF};
                tmr_load = TMR_W'(PROG_CYCLES);
            end
            K_SERASE:
            begin
                base     = cmd_reg.addr & SECT_MASK;
                last     = (cmd_reg.addr & SECT_MASK) | SECT_SPAN;
                tmr_load = TMR_W'(SECT_CYCLES);
            end
            K_BERASE:
            begin
                base     = cmd_reg.addr & BLOCK_MASK;
                last     = (cmd_reg.addr & BLOCK_MASK) | BLOCK_SPAN;
                tmr_load = TMR_W'(BLOCK_CYCLES);
            end
            default:
            begin
                base     = '0;
                last     = ARRAY_LAST;
                tmr_load = TMR_W'(CHIP_CYCLES);
            end
        endcase
    end

    // Locks cover the array top, so the range end decides the refusal
    assign refuse = (cmd_reg.kind != K_CERASE) && sfrpe_locked(last, BP);
    assign start  = cs_rise && complete_reg && WEL && !refuse;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (start)
                    state_next = ST_WRITE;
            ST_WRITE:
                if (ptr_reg == end_reg)
                    state_next = ST_WAIT;
            ST_WAIT:
                if (tmr_reg == '0)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            ptr_reg   <= '0;
            end_reg   <= '0;
            erase_reg <= 1'b0;
        end
        else if (state_reg == ST_IDLE && start)
        begin
            ptr_reg   <= base;
            end_reg   <= last;
            erase_reg <= (cmd_reg.kind != K_PROG);
        end
        else if (state_reg == ST_WRITE && ptr_reg != end_reg)
            ptr_reg <= ptr_reg + 17'h00001;
    end

    // Array write sweep, one byte per core cycle
    always_ff @(posedge CORE_CLK)
    begin
        if (state_reg == ST_WRITE && !sfrpe_locked(ptr_reg, BP))
        begin
            if (erase_reg)
                mem_arr[ptr_reg] <= 8'hFF;
            else if (mask_reg[ptr_reg[7:0]])
                mem_arr[ptr_reg] <= mem_arr[ptr_reg] &
                                    page_buf[ptr_reg[7:0]];
        end
    end

    // Self-timed duration runs alongside the sweep
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            tmr_reg <= '0;
        else if (state_reg == ST_IDLE && start)
            tmr_reg <= tmr_load;
        else if (tmr_reg != '0)
            tmr_reg <= tmr_reg - {{(TMR_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            busy_reg <= 1'b0;
        else
            busy_reg <= (state_next != ST_IDLE);
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            wel_clr_reg <= 1'b0;
        else
            wel_clr_reg <= (state_reg == ST_DONE);
    end

    assign BUSY    = busy_reg;
    assign WEL_CLR = wel_clr_reg;

endmodule // sfrpe_core

/* File: bench/sfrpe_host.sv */
// Host serial controller model: chip select, serial clock and data in.
// Assumes the bench resolves the device output onto so_line (Z when off).
`timescale 1ns/10ps
module sfrpe_host
(
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so_line
);
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // Odd offsets keep every link edge off the core clock edges
    task automatic open();
        #5;
        cs_n = 1'b0;
        #6;
    endtask

    // Clock stands low outside frames; data moves while clock is low
    task automatic shift(input int n, input logic [7:0] tx,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = tx[i];
            #6;
            sck = 1'b1;
            rx[i] = so_line;
            #6;
            sck = 1'b0;
        end
    endtask

    // Rise inside the low phase right after the last bit; SI goes stale
    task automatic close();
        #2;
        cs_n = 1'b1;
        si   = ~si;
        #401;
    endtask
endmodule // sfrpe_host

/* File: bench/sfrpe_core_sva.sv */
// Port assertions for the flash command sequencer.
// Assumes a mode 0 host; bound to every sequencer instance below.
`timescale 1ns/10ps
module sfrpe_core_sva
    import sfrpe_pkg::*;
#(
    parameter logic [7:0]  OP_FAST_READ = 8'h0B,
    parameter int unsigned CHIP_CYCLES  = CHIP_ERASE_CYC
)
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic SO_OE,
    input wire logic WEL,
    input wire logic BUSY,
    input wire logic WEL_CLR
);
    logic [TMR_W-1:0] busy_len;
    logic [5:0]       edge_cnt;
    logic [7:0]       op_seen;

    always_ff @(posedge CORE_CLK)
        if (RST || !BUSY)
            busy_len <= '0;
        else
            busy_len <= busy_len + 1'b1;

    // Cleared by chip select so a short frame never leaks into the next
    always_ff @(posedge SCK or posedge CS_N or posedge RST)
        if (RST || CS_N)
            edge_cnt <= '0;
        else if (edge_cnt != CNT_SAT)
            edge_cnt <= edge_cnt + 1'b1;

    always_ff @(posedge SCK or posedge CS_N or posedge RST)
        if (RST || CS_N)
            op_seen <= '0;
        else if (edge_cnt <= OPC_LAST)
            op_seen <= {op_seen[6:0], SI};

    a_busy_needs_wel: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(BUSY) |-> $past(WEL))
        else $error("busy started without write enable");
    a_start_after_cs: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(BUSY) |-> $past(CS_N, 3))
        else $error("busy started inside a frame");
    a_clr_at_end: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(BUSY) |-> WEL_CLR)
        else $error("no enable clear at end of cycle");
    a_clr_one_cycle: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        WEL_CLR |=> !WEL_CLR)
        else $error("enable clear longer than one cycle");
    a_clr_cause: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        WEL_CLR |-> $past(BUSY) && !BUSY)
        else $error("enable clear without busy end");
    a_busy_min_len: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(BUSY) |-> busy_len >= 255)
        else $error("busy shorter than a page sweep");
    a_busy_max_len: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        BUSY |-> busy_len <= CHIP_CYCLES + 16)
        else $error("busy never ends");
    a_oe_off_idle: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        CS_N |-> !SO_OE)
        else $error("output driven while deselected");
    a_oe_off_early: assert property (
        @(posedge SCK) disable iff (RST || CS_N)
        edge_cnt < RD_START |-> !SO_OE)
        else $error("output driven before dummy byte ends");
    a_oe_on_data: assert property (
        @(posedge SCK) disable iff (RST || CS_N)
        edge_cnt >= RD_START && op_seen == OP_FAST_READ |-> SO_OE)
        else $error("fast read output not driven");
endmodule // sfrpe_core_sva

bind sfrpe_core sfrpe_core_sva #(
    .OP_FAST_READ(OP_FAST_READ),
    .CHIP_CYCLES (CHIP_CYCLES)
) chk (
    .CORE_CLK(CORE_CLK),
    .RST     (RST),
    .SCK     (SCK),
    .CS_N    (CS_N),
    .SI      (SI),
    .SO_OE   (SO_OE),
    .WEL     (WEL),
    .BUSY    (BUSY),
    .WEL_CLR (WEL_CLR)
);

/* File: bench/tb_top.sv */
// Bench for the flash sequencer: host model, enable neighbour, checks.
// Assumes the checker binds itself; timers are shortened by parameters.
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] rd_op = 8'h0B;
    localparam logic [7:0] pg_op = 8'h02;
    localparam logic [7:0] se_op = 8'h20;
    localparam logic [7:0] be_op = 8'h52;
    localparam logic [7:0] ce_op = 8'h60;

    logic       core_clk    = 1'b0;
    logic       rst;
    logic       wel         = 1'b0;
    logic [3:0] bp          = 4'h0;
    wire        cs_n;
    wire        sck;
    wire        si;
    wire        so;
    wire        so_oe;
    wire        busy;
    wire        wel_clr;
    wire        so_line     = so_oe ? so : 1'bz;
    int         failures    = 0;
    int         comparisons = 0;

    always #20 core_clk = ~core_clk;

    sfrpe_core #(
        .OP_FAST_READ(rd_op), .OP_PROGRAM(pg_op), .OP_SECT_ERS(se_op),
        .OP_BLOCK_ERS(be_op), .OP_CHIP_ERS(ce_op), .PROG_CYCLES(300),
        .SECT_CYCLES(5000), .BLOCK_CYCLES(40000), .CHIP_CYCLES(140000)
    ) uut (
        .CORE_CLK(core_clk), .RST(rst), .SCK(sck), .CS_N(cs_n),
        .SI(si), .SO(so), .SO_OE(so_oe), .WEL(wel), .BP(bp),
        .BUSY(busy), .WEL_CLR(wel_clr)
    );

    sfrpe_host host (.cs_n(cs_n), .sck(sck), .si(si), .so_line(so_line));

    // Neighbour logic drops write enable on the completion pulse
    always @(posedge core_clk)
        if (wel_clr === 1'b1)
            wel <= 1'b0;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic arm(input logic w, input logic [3:0] b);
        @(posedge core_clk);
        wel <= w;
        bp  <= b;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                       input int na);
        logic [7:0] r;
        host.open();
        host.shift(8, op, r);
        for (int i = na - 1; i >= 0; i--)
            host.shift(8, a[i*8 +: 8], r);
    endtask

    task automatic erase(input logic [7:0] op, input logic [23:0] a,
                         input int na);
        cmd(op, a, na);
        host.close();
    endtask

    task automatic rd(input logic [23:0] a, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] r;
        cmd(rd_op, a, 3);
        host.shift(8, 8'h00, r);
        check(r, 8'hZZ);
        host.shift(8, 8'h00, r);
        check(r, e0);
        if (n > 1)
        begin
            host.shift(8, 8'h00, r);
            check(r, e1);
        end
        host.close();
    endtask

    task automatic prog(input logic [23:0] a, input logic [7:0] d[$],
                        input int tail);
        logic [7:0] r;
        cmd(pg_op, a, 3);
        foreach (d[i])
            host.shift(8, d[i], r);
        if (tail > 0)
            host.shift(tail, 8'hFF, r);
        host.close();
    endtask

    // Waits are bounded; a stuck busy shows up as a mismatch
    task automatic op_done(input logic go, input int lim);
        logic w0;
        int   k;
        w0 = wel;
        k  = 0;
        while (busy !== 1'b1 && k < 12)
        begin
            @(negedge core_clk);
            k++;
        end
        check(8'(busy), 8'(go));
        k = 0;
        while (busy === 1'b1 && k < lim)
        begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        check(8'(busy), 8'h00);
        check(8'(wel), 8'(w0 & ~go));
    endtask

    task automatic s_erase();
        arm(1'b1, 4'h0);
        erase(se_op, 24'hFE0123, 3);
        op_done(1'b1, 6000);
        arm(1'b1, 4'h0);
        erase(se_op, 24'h01F456, 3);
        op_done(1'b1, 6000);
        rd(24'h000000, 2, 8'hFF, 8'hFF);
        rd(24'h000FFF, 1, 8'hFF, 8'h00);
        rd(24'h01F000, 1, 8'hFF, 8'h00);
    endtask

    task automatic s_prog();
        arm(1'b1, 4'h0);
        prog(24'h0000FE, '{8'hA5, 8'h3C, 8'h0F}, 0);
        op_done(1'b1, 400);
        rd(24'h0000FE, 2, 8'hA5, 8'h3C);
        rd(24'h000000, 2, 8'h0F, 8'hFF);
        arm(1'b1, 4'h0);
        prog(24'h0000FE, '{8'h5A}, 0);
        op_done(1'b1, 400);
        rd(24'h0000FE, 1, 8'h00, 8'h00);
        arm(1'b0, 4'h0);
        prog(24'h000010, '{8'h00}, 0);
        op_done(1'b0, 0);
        erase(ce_op, 24'h000000, 0);
        op_done(1'b0, 0);
        arm(1'b1, 4'h0);
        prog(24'h000011, '{8'h00}, 3);
        op_done(1'b0, 0);
        rd(24'h000010, 2, 8'hFF, 8'hFF);
    endtask

    task automatic s_wrap();
        arm(1'b1, 4'h0);
        prog(24'h01FFFF, '{8'h96}, 0);
        op_done(1'b1, 400);
        rd(24'h01FFFF, 2, 8'h96, 8'h0F);
    endtask

    task automatic s_lock();
        arm(1'b1, 4'h4);
        erase(se_op, 24'h01F000, 3);
        op_done(1'b0, 0);
        prog(24'h01FFFE, '{8'h00}, 0);
        op_done(1'b0, 0);
        erase(be_op, 24'h018000, 3);
        op_done(1'b0, 0);
        arm(1'b0, 4'h0);
        rd(24'h01FFFE, 2, 8'hFF, 8'h96);
    endtask

    task automatic s_busy();
        arm(1'b1, 4'h0);
        erase(se_op, 24'h001000, 3);
        check(8'(busy), 8'h01);
        prog(24'h001000, '{8'h00}, 0);
        op_done(1'b1, 6000);
        rd(24'h001000, 1, 8'hFF, 8'h00);
    endtask

    task automatic s_block();
        arm(1'b1, 4'h0);
        erase(be_op, 24'h00ABCD, 3);
        op_done(1'b1, 42000);
        rd(24'h008000, 1, 8'hFF, 8'h00);
        rd(24'h00FFFF, 1, 8'hFF, 8'h00);
    endtask

    task automatic give_verdict();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        // Scheduled so the link-side flops see a reset edge
        rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        s_erase();
        s_prog();
        s_wrap();
        s_lock();
        s_busy();
        s_block();
        give_verdict();
    end

    // About 57k core cycles expected; this leaves ample margin
    initial
    begin
        #4_000_000;
        failures++;
        give_verdict();
    end
endmodule // tb_top
